// File: src/dual_slope_pwm_timer.sv
// 8-bit timer with dual-slope pwm, compare outputs and axi4-lite regs
`timescale 1ns/10ps
module dual_slope_pwm_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ptm_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ptm_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic wave_out_a,
    output logic wave_out_a_oe_n,
    output logic wave_out_b,
    output logic wave_out_b_oe_n,
    output logic irq
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic aw_full_ff;
    logic w_full_ff;
    logic [7:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_wr;
    logic wr_sel;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] count_ff;
    ptm_pkg::dir_t dir_ff;
    logic [7:0] cmp_buf_ff [2];
    logic [7:0] cmp_act_ff [2];
    logic [2:0] status_ff;
    logic [2:0] enable_ff;
    logic [1:0] pin_dir_ff;
    logic [7:0] div_ff;
    logic [7:0] div_cnt_ff;
    logic [2:0] mode;
    logic pwm_phase;
    logic pwm_fast;
    logic [7:0] top;
    logic tick;
    logic count_wr;
    logic [1:0] cmp_wr;
    logic wrap_set;
    logic [1:0] match_w;
    logic [1:0] pin_w;
    logic [1:0] oe_n_w;
    logic [2:0] clr_w;
    logic [2:0] set_w;

    wave_bus_if wbus ();

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    // address and data are caught separately, in either order
    assign awready = ~aw_full_ff;
    assign wready = ~w_full_ff;
    assign do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign wr_sel = do_wr & wstrb_ff[0];
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            waddr_ff <= 8'h00;
        end else if (awvalid && awready) begin
            aw_full_ff <= 1'b1;
            waddr_ff <= {awaddr[7:2], 2'b00};
        end else if (do_wr) begin
            aw_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
        end else if (do_wr) begin
            w_full_ff <= 1'b0;
        end
    end

    always_comb begin
        case (waddr_ff)
            ptm_pkg::OFS_CTRL_A, ptm_pkg::OFS_CTRL_B, ptm_pkg::OFS_COUNT,
            ptm_pkg::OFS_CMP_A, ptm_pkg::OFS_CMP_B, ptm_pkg::OFS_STATUS,
            ptm_pkg::OFS_CLEAR, ptm_pkg::OFS_ENABLE, ptm_pkg::OFS_PIN_DIR,
            ptm_pkg::OFS_TICK_DIV: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= ptm_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? ptm_pkg::RESP_OKAY : ptm_pkg::RESP_DECERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    assign arready = ~rvalid_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h0000_0000;
        case ({araddr[7:2], 2'b00})
            ptm_pkg::OFS_CTRL_A: rd_data[7:0] = ctrl_a_ff;
            ptm_pkg::OFS_CTRL_B: rd_data[7:0] = ctrl_b_ff;
            ptm_pkg::OFS_COUNT: rd_data[7:0] = count_ff;
            ptm_pkg::OFS_CMP_A: rd_data[7:0] = cmp_buf_ff[0];
            ptm_pkg::OFS_CMP_B: rd_data[7:0] = cmp_buf_ff[1];
            ptm_pkg::OFS_STATUS: rd_data[2:0] = status_ff;
            ptm_pkg::OFS_CLEAR: rd_data = 32'h0000_0000;
            ptm_pkg::OFS_ENABLE: rd_data[2:0] = enable_ff;
            ptm_pkg::OFS_PIN_DIR: rd_data[1:0] = pin_dir_ff;
            ptm_pkg::OFS_TICK_DIV: rd_data[7:0] = div_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= ptm_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_data;
            rresp_ff <= rd_hit ? ptm_pkg::RESP_OKAY : ptm_pkg::RESP_DECERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // reserved bits are masked at write so they read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_ff <= ptm_pkg::REG_RST;
            ctrl_b_ff <= ptm_pkg::REG_RST;
            enable_ff <= 3'h0;
            pin_dir_ff <= 2'h0;
            div_ff <= ptm_pkg::REG_RST;
        end else if (wr_sel) begin
            case (waddr_ff)
                ptm_pkg::OFS_CTRL_A:
                    ctrl_a_ff <= wdata_ff[7:0] & ptm_pkg::CTRL_A_MASK;
                ptm_pkg::OFS_CTRL_B:
                    ctrl_b_ff <= wdata_ff[7:0] & ptm_pkg::CTRL_B_MASK;
                ptm_pkg::OFS_ENABLE: enable_ff <= wdata_ff[2:0];
                ptm_pkg::OFS_PIN_DIR: pin_dir_ff <= wdata_ff[1:0];
                ptm_pkg::OFS_TICK_DIV: div_ff <= wdata_ff[7:0];
                default: ;
            endcase
        end
    end

    assign count_wr = wr_sel & (waddr_ff == ptm_pkg::OFS_COUNT);
    assign cmp_wr[0] = wr_sel & (waddr_ff == ptm_pkg::OFS_CMP_A);
    assign cmp_wr[1] = wr_sel & (waddr_ff == ptm_pkg::OFS_CMP_B);

    // ----------------------------------------------------------------
    // mode decode and timer tick
    // ----------------------------------------------------------------
    assign mode = {ctrl_b_ff[ptm_pkg::MODE_MSB_BIT], ctrl_a_ff[1:0]};
    assign pwm_phase = (mode == ptm_pkg::MODE_PHASE_MAX) |
                       (mode == ptm_pkg::MODE_PHASE_CMP);
    assign pwm_fast = (mode == ptm_pkg::MODE_FAST_MAX) |
                      (mode == ptm_pkg::MODE_FAST_CMP);
    assign top = (mode[2] | (mode == ptm_pkg::MODE_CTC)) ?
                 cmp_act_ff[0] : ptm_pkg::MAX;

    // divided enable, never a derived clock
    assign tick = ctrl_b_ff[ptm_pkg::RUN_BIT] & (div_cnt_ff == div_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_ff <= 8'h00;
        end else if (tick || !ctrl_b_ff[ptm_pkg::RUN_BIT]) begin
            div_cnt_ff <= 8'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= ptm_pkg::BOTTOM;
            dir_ff <= ptm_pkg::DIR_UP;
        end else if (count_wr) begin
            count_ff <= wdata_ff[7:0];
        end else if (tick && pwm_phase) begin
            case (dir_ff)
                ptm_pkg::DIR_UP: begin
                    if (count_ff >= top) begin
                        count_ff <= (count_ff == ptm_pkg::BOTTOM) ?
                                    ptm_pkg::BOTTOM : count_ff - 8'h01;
                        dir_ff <= ptm_pkg::DIR_DOWN;
                    end else begin
                        count_ff <= count_ff + 8'h01;
                    end
                end
                ptm_pkg::DIR_DOWN: begin
                    if (count_ff == ptm_pkg::BOTTOM) begin
                        count_ff <= (top == ptm_pkg::BOTTOM) ?
                                    ptm_pkg::BOTTOM : 8'h01;
                        dir_ff <= ptm_pkg::DIR_UP;
                    end else begin
                        count_ff <= count_ff - 8'h01;
                    end
                end
                default: dir_ff <= ptm_pkg::DIR_UP;
            endcase
        end else if (tick) begin
            dir_ff <= ptm_pkg::DIR_UP;
            count_ff <= (count_ff == top) ?
                        ptm_pkg::BOTTOM : count_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // compare buffers
    // ----------------------------------------------------------------
    // pwm modes load at top so a duty change never splits a period
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                cmp_buf_ff[i] <= ptm_pkg::REG_RST;
                cmp_act_ff[i] <= ptm_pkg::REG_RST;
            end else begin
                if (cmp_wr[i]) begin
                    cmp_buf_ff[i] <= wdata_ff[7:0];
                end
                if (!(pwm_phase || pwm_fast) || wbus.at_top) begin
                    cmp_act_ff[i] <= cmp_buf_ff[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // shared channel state
    // ----------------------------------------------------------------
    assign wbus.tick = tick;
    assign wbus.at_top = tick & (count_ff == top);
    assign wbus.at_bottom = tick & (count_ff == ptm_pkg::BOTTOM);
    // bottom counts as up-going, top as down-going
    assign wbus.eff_up = ~pwm_phase | (count_ff == ptm_pkg::BOTTOM) |
                         ((count_ff < top) & (dir_ff == ptm_pkg::DIR_UP));
    assign wbus.pwm_fast = pwm_fast;
    assign wbus.pwm_phase = pwm_phase;
    assign wbus.mode_msb = mode[2];
    assign wbus.count = count_ff;
    assign wbus.top = top;

    // ----------------------------------------------------------------
    // compare output channels
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_chan
        localparam int ALSB = (g == 0) ? ptm_pkg::CHAN_A_ACT_LSB :
                                         ptm_pkg::CHAN_B_ACT_LSB;
        wave_chan_unit #(
            .HAS_TOGGLE(g == 0)
        ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .bus(wbus),
            .action(ctrl_a_ff[ALSB+1:ALSB]),
            .cmp(cmp_act_ff[g]),
            .drive_dir(pin_dir_ff[g]),
            .match(match_w[g]),
            .pin_out(pin_w[g]),
            .pin_oe_n(oe_n_w[g])
        );
    end

    assign wave_out_a = pin_w[0];
    assign wave_out_a_oe_n = oe_n_w[0];
    assign wave_out_b = pin_w[1];
    assign wave_out_b_oe_n = oe_n_w[1];

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    assign wrap_set = tick & (pwm_phase ?
        ((count_ff == ptm_pkg::BOTTOM) & (dir_ff == ptm_pkg::DIR_DOWN)) :
        pwm_fast ? (count_ff == top) : (count_ff == ptm_pkg::MAX));
    assign set_w = {match_w[1], match_w[0], wrap_set};
    assign clr_w = (wr_sel && waddr_ff == ptm_pkg::OFS_CLEAR) ?
                   wdata_ff[2:0] : 3'h0;

    // a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff & ~clr_w) | set_w;
        end
    end

    assign irq = |(status_ff & enable_ff);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_dual_slope_up:
    assert property (@(posedge aclk) disable iff (!aresetn)
        tick && pwm_phase && !count_wr && dir_ff == ptm_pkg::DIR_UP &&
        count_ff < top |=> count_ff == $past(count_ff) + 8'h01)
    else $error("dual-slope count did not step up");

    a_top_turnaround:
    assert property (@(posedge aclk) disable iff (!aresetn)
        tick && pwm_phase && !count_wr && dir_ff == ptm_pkg::DIR_UP &&
        count_ff == top && top != 8'h00
        |=> count_ff == $past(top) - 8'h01 && dir_ff == ptm_pkg::DIR_DOWN)
    else $error("counter did not turn at top");

    a_wrap_at_bottom:
    assert property (@(posedge aclk) disable iff (!aresetn)
        tick && pwm_phase && count_ff == 8'h00 &&
        dir_ff == ptm_pkg::DIR_DOWN |=> status_ff[0])
    else $error("wrap flag missing at bottom");

    a_tick_enable_only:
    assert property (@(posedge aclk) disable iff (!aresetn)
        !tick && !count_wr |=> $stable(count_ff))
    else $error("counter moved without tick");

    a_cmp_buffer_hold:
    assert property (@(posedge aclk) disable iff (!aresetn)
        pwm_phase && !wbus.at_top ##1 pwm_phase |-> $stable(cmp_act_ff[0]))
    else $error("compare loaded away from top");

    a_set_beats_clear:
    assert property (@(posedge aclk) disable iff (!aresetn)
        wrap_set && clr_w[0] |=> status_ff[0])
    else $error("clear lost a wrap event");

    a_bresp_stable:
    assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule : dual_slope_pwm_timer

// File: pkg/ptm_pkg.sv
// constants and types shared by the dual-slope pwm timer
package ptm_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0c;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CLEAR = 8'h18;
    localparam logic [7:0] OFS_ENABLE = 8'h1c;
    localparam logic [7:0] OFS_PIN_DIR = 8'h20;
    localparam logic [7:0] OFS_TICK_DIV = 8'h24;
    // ----------------------------------------------------------------
    // field positions, masks and reset values
    // ----------------------------------------------------------------
    localparam int CHAN_A_ACT_LSB = 6;
    localparam int CHAN_B_ACT_LSB = 4;
    localparam int MODE_MSB_BIT = 3;
    localparam int RUN_BIT = 0;
    localparam int WRAP_BIT = 0;
    localparam int MATCH_A_BIT = 1;
    localparam int MATCH_B_BIT = 2;
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_MASK = 8'h09;
    localparam logic [7:0] REG_RST = 8'h00;
    // ----------------------------------------------------------------
    // counter values, mode codes, bus answers
    // ----------------------------------------------------------------
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hff;
    localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
    localparam logic [2:0] MODE_CTC = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;
endpackage : ptm_pkg

// File: pkg/wave_bus_if.sv
// shared counter state passed from the timer core to its channels
`timescale 1ns/10ps
interface wave_bus_if;
    logic tick;
    logic at_top;
    logic at_bottom;
    logic eff_up;
    logic pwm_fast;
    logic pwm_phase;
    logic mode_msb;
    logic [7:0] count;
    logic [7:0] top;
    modport timer(output tick, at_top, at_bottom, eff_up, pwm_fast,
                  pwm_phase, mode_msb, count, top);
    modport chan(input tick, at_top, at_bottom, eff_up, pwm_fast,
                 pwm_phase, mode_msb, count, top);
endinterface : wave_bus_if

// File: src/wave_chan_unit.sv
// one compare output channel: action decode and output level
`timescale 1ns/10ps
module wave_chan_unit #(
    parameter bit HAS_TOGGLE = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    wave_bus_if.chan bus,
    input wire logic [1:0] action,
    input wire logic [7:0] cmp,
    input wire logic drive_dir,
    output logic match,
    output logic pin_out,
    output logic pin_oe_n
);
    logic level_ff;
    logic nxt_level;
    logic [1:0] held_ff;
    logic pwm;
    logic tog_ok;
    logic linked;
    logic cmp_is_top;

    // ----------------------------------------------------------------
    // action decode
    // ----------------------------------------------------------------
    assign pwm = bus.pwm_fast | bus.pwm_phase;
    assign tog_ok = pwm ? (HAS_TOGGLE & bus.mode_msb) : 1'b1;
    assign cmp_is_top = (cmp == bus.top);
    assign match = bus.tick & (bus.count == cmp);
    // reserved pwm toggle code leaves the pin to the port
    assign linked = (held_ff != 2'h0) & ((held_ff != 2'h1) | tog_ok);

    always_comb begin
        nxt_level = level_ff;
        if (match) begin
            if (action == 2'h1) begin
                if (tog_ok) begin
                    nxt_level = ~level_ff;
                end
            end else if (action[1]) begin
                if (bus.pwm_phase) begin
                    nxt_level = action[0] ^ ~bus.eff_up;
                end else if (!(bus.pwm_fast && cmp_is_top)) begin
                    nxt_level = action[0];
                end
            end
        end
        if (bus.pwm_fast && bus.at_top && held_ff[1]) begin
            nxt_level = ~held_ff[0];
        end
        // forced level at bottom keeps the wave symmetric
        if (bus.pwm_phase && bus.at_bottom && held_ff[1]) begin
            nxt_level = (cmp != ptm_pkg::BOTTOM) ^ held_ff[0];
        end
    end

    // ----------------------------------------------------------------
    // output level and latched action
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
        end
    end

    // new action code only becomes the live one at a match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            held_ff <= 2'h0;
        end else if (match) begin
            held_ff <= action;
        end
    end

    assign pin_out = level_ff;
    assign pin_oe_n = ~(linked & drive_dir);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_toggle_on_match:
    assert property (@(posedge aclk) disable iff (!aresetn)
        match && action == 2'h1 && held_ff == 2'h1 && tog_ok
        |=> pin_out != $past(pin_out))
    else $error("output did not toggle on match");

    a_bottom_symmetry:
    assert property (@(posedge aclk) disable iff (!aresetn)
        bus.pwm_phase && bus.at_bottom && held_ff[1]
        |=> pin_out == (($past(cmp) != 8'h00) ^ $past(held_ff[0])))
    else $error("wrong level after bottom");

    a_no_pwm_toggle:
    assert property (@(posedge aclk) disable iff (!aresetn)
        !tog_ok && held_ff == 2'h1 |-> pin_oe_n)
    else $error("pin driven with reserved toggle code");
endmodule : wave_chan_unit

// File: verification/pin_load_model.sv
// port pin loads seen by the timer outputs
`timescale 1ns/10ps
module pin_load_model (
    input wire logic [1:0] pin,
    input wire logic [1:0] oe_n,
    output logic [1:0] level
);
    // a released pin falls to the pull-down, never keeps its last level
    assign level[0] = oe_n[0] ? 1'b0 : pin[0];
    assign level[1] = oe_n[1] ? 1'b0 : pin[1];
endmodule : pin_load_model

// File: verification/dual_slope_pwm_timer_tb.sv
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/10ps
module dual_slope_pwm_timer_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rs, act;
    wire [1:0] pin, oe_n, lvl;
    logic awready, wready, bvalid, arready, rvalid, irq;
    int n_mismatch = 0, samples_checked = 0, hi, lo, c;
    dual_slope_pwm_timer i_dual_slope_pwm_timer (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .wave_out_a(pin[0]), .wave_out_a_oe_n(oe_n[0]),
        .wave_out_b(pin[1]), .wave_out_b_oe_n(oe_n[1]), .irq);
    pin_load_model i_pin_load_model (.pin, .oe_n, .level(lvl));
    initial begin
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", 32'(bresp), 32'(ptm_pkg::RESP_OKAY));
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdr
    // high and low spans of pin a, from one rising edge
    task automatic meas(output int h, output int l);
        while (lvl[0] !== 1'b0) @(posedge aclk);
        while (lvl[0] !== 1'b1) @(posedge aclk);
        h = 0;
        l = 0;
        while (lvl[0] === 1'b1) begin
            @(posedge aclk);
            h++;
        end
        while (lvl[0] === 1'b0) begin
            @(posedge aclk);
            l++;
        end
    endtask : meas
    // high samples of pin a over n clocks, once the level has settled
    task automatic cnt_hi(input int n, output int h);
        repeat (1200) @(posedge aclk);
        h = 0;
        repeat (n) begin
            @(posedge aclk);
            if (lvl[0] === 1'b1) h++;
        end
    endtask : cnt_hi
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        c = $urandom(32'hfa8ad32f);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(ptm_pkg::OFS_CTRL_A);
        chk("ctrl_a", rd, 32'h0);
        rdr(8'h3c);
        chk("unmapped", 32'(rs), 32'(ptm_pkg::RESP_DECERR));
        chk("oe_idle", 32'(oe_n), 32'h3);
        wr(ptm_pkg::OFS_PIN_DIR, 8'h03);
        wr(ptm_pkg::OFS_ENABLE, 8'h01);
        wr(ptm_pkg::OFS_CTRL_B, 8'h01);
        // duty corners first, then random compare values
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 1 : (i == 1) ? 254 : 1 + $urandom_range(253);
            act = i[0] ? 2'h3 : 2'h2;
            wr(ptm_pkg::OFS_CMP_A, 8'(c));
            rdr(ptm_pkg::OFS_CMP_A);
            chk("cmp_a", rd, 32'(c));
            wr(ptm_pkg::OFS_CTRL_A, {act, 6'h01});
            meas(hi, lo);
            meas(hi, lo);
            chk("period", 32'(hi + lo), 32'h1fe);
            c = act[0] ? 510 - 2 * c : 2 * c;
            chk("high", 32'(hi), 32'(c));
        end
        // steady levels at the compare extremes, channel b on a zero compare ends driven high
        for (int k = 0; k < 4; k++) begin
            act = k[0] ? 2'h3 : 2'h2;
            wr(ptm_pkg::OFS_CMP_A, k[1] ? 8'hff : 8'h00);
            wr(ptm_pkg::OFS_CTRL_A, {act, act, 4'h1});
            cnt_hi(510, hi);
            c = (k[1] ^ k[0]) ? 510 : 0;
            chk("extreme", 32'(hi), 32'(c));
        end
        chk("oe_b", 32'(oe_n[1]), 32'h0);
        chk("level_b", 32'(lvl[1]), 32'h1);
        // fast pwm: set at top, clear at match
        wr(ptm_pkg::OFS_CTRL_A, 8'h83);
        wr(ptm_pkg::OFS_CMP_A, 8'h40);
        meas(hi, lo);
        meas(hi, lo);
        chk("fast_period", 32'(hi + lo), 32'h100);
        chk("fast_high", 32'(hi), 32'h41);
        wr(ptm_pkg::OFS_CMP_A, 8'hff);
        cnt_hi(256, hi);
        chk("fast_top", 32'(hi), 32'h100);
        chk("oe_a", 32'(oe_n[0]), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        wr(ptm_pkg::OFS_ENABLE, 8'h00);
        chk("irq_mask", 32'(irq), 32'h0);
        // clears against wrap events, gaps of four and five clocks
        for (int j = 0; j < 600; j++) begin
            wr(ptm_pkg::OFS_CLEAR, 8'h01);
            if (j[0]) @(posedge aclk);
        end
        wr(ptm_pkg::OFS_CTRL_B, 8'h00);
        wr(ptm_pkg::OFS_CLEAR, 8'h07);
        rdr(ptm_pkg::OFS_STATUS);
        chk("status", rd, 32'h0);
        wr(ptm_pkg::OFS_COUNT, 8'h00);
        wr(ptm_pkg::OFS_CMP_A, 8'h40);
        wr(ptm_pkg::OFS_CTRL_A, 8'h51);
        wr(ptm_pkg::OFS_CTRL_B, 8'h09);
        meas(hi, lo);
        meas(hi, lo);
        chk("toggle_hi", 32'(hi), 32'h80);
        chk("toggle_lo", 32'(lo), 32'h80);
        chk("oe_b_toggle", 32'(oe_n[1]), 32'h1);
        chk("level_b_off", 32'(lvl[1]), 32'h0);
        close_out();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        close_out();
    end
endmodule : dual_slope_pwm_timer_tb
